// ==== hw/csc_regs.svh ====
// Register offsets, field positions, reset values and codes of the clock source control block.
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH
`define CSC_ADDR_PIN_MODE 20'hf_ffa0
`define CSC_ADDR_STOP_CTRL 20'hf_ffa1
`define CSC_PIN_MODE_RESET 8'h00
`define CSC_STOP_CTRL_RESET 8'hc0
`define CSC_PIN_MODE_MASK 8'hd1
`define CSC_STOP_CTRL_MASK 8'hc1
`define CSC_BIT_EXT_CLOCK_SELECT 7
`define CSC_BIT_MAIN_OSC_PIN_SELECT 6
`define CSC_BIT_SUB_OSC_PIN_SELECT 4
`define CSC_BIT_MAIN_OSC_GAIN_HIGH 0
`define CSC_BIT_HIGHSPEED_CLOCK_STOP 7
`define CSC_BIT_SUB_CLOCK_STOP 6
`define CSC_BIT_INTERNAL_OSC_STOP 0
`define CSC_MODE_PORT_A 2'b00
`define CSC_MODE_CRYSTAL 2'b01
`define CSC_MODE_PORT_B 2'b10
`define CSC_MODE_EXT_CLOCK 2'b11
`endif

// ==== hw/csc_pkg.sv ====
// Types shared by the clock source control block.
package csc_pkg;
  typedef struct packed {
    logic main_crystal_oscillator_run;
    logic ext_clock_valid;
    logic sub_crystal_oscillator_run;
    logic internal_osc_run;
    logic main_osc_gain_high;
  } csc_osc_ctrl_t;
  typedef enum logic [1:0] {
    CSC_CFG_OPEN = 2'b01,
    CSC_CFG_LOCKED = 2'b10
  } csc_cfg_state_t;
endpackage

// ==== hw/csc_clock_source_ctrl.sv ====
// Pin mode configuration and oscillator stop control of the clock generator.
// Operation
// RULE_01 - First byte write after reset loads the pin mode configuration register.
// RULE_02 - All later writes to pin mode configuration are ignored until reset.
// RULE_03 - Pin mode configuration readable by bit or byte at any time.
// RULE_04 - Reset clears pin mode configuration to zero, both pin pairs ports.
// RULE_05 - Bits 7:6 select port (00,10), crystal (01) or external clock (11).
// RULE_06 - Bit 4 selects sub pins port (0) or crystal oscillation (1).
// RULE_07 - Bit 0 selects main gain range; software sets it above 10 MHz.
// RULE_08 - Software writes pin mode configuration before starting crystal oscillators.
// RULE_09 - Software should rewrite default zero after reset anyway.
// RULE_10 - Reset sets stop control to C0H; bit and byte writes accepted.
// RULE_11 - Bit 7 zero runs main crystal or validates external clock; none in port mode.
// RULE_12 - Bit 6 zero runs sub crystal; no effect in sub port mode.
// RULE_13 - Bit 0 zero runs internal oscillator, one stops it.
// RULE_14 - Software checks stabilization status before using the main crystal clock.
// RULE_15 - Software never stops the clock currently driving the CPU.
// RULE_16 - Main stop only with CPU on subclock, or main source internal.
// RULE_17 - Sub stop only while CPU is not on subclock.
// RULE_18 - Internal stop only with CPU on subclock, or main source high speed.
// RULE_19 - Status flags show CPU on subclock and main source high speed.
// RULE_20 - After reset the CPU runs from the internal high-speed oscillator.
// RULE_21 - Setting main stop clears the stabilization counter status.
`timescale 1ns/10ps
`include "csc_regs.svh"
module csc_clock_source_ctrl
  import csc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [19:0] bus_addr,
  input wire logic bus_write,
  input wire logic bus_byte,
  input wire logic [2:0] bus_bit,
  input wire logic [7:0] bus_wdata,
  input wire logic cpu_clock_select_sub,
  input wire logic main_clock_select_highspeed,
  output logic [7:0] bus_rdata,
  output csc_osc_ctrl_t osc_ctrl,
  output logic cpu_on_subclock_flag,
  output logic main_source_is_highspeed_flag,
  output logic cpu_clock_from_highspeed,
  output logic stabilization_clear
);
  logic [7:0] clock_pin_mode_config;
  logic [7:0] clock_osc_stop_control;
  csc_cfg_state_t cfg_state;
  logic [7:0] next_pin_mode;
  logic [7:0] next_stop_ctrl;
  csc_osc_ctrl_t next_osc_ctrl;
  logic [7:0] next_rdata;
  logic next_cpu_on_subclock_flag;
  logic next_main_source_is_highspeed_flag;
  logic next_cpu_from_highspeed;
  logic next_stabilization_clear;

  // Oscillator enables while reset is held: only the internal oscillator runs.
  // This matches the stop control reset value, so the outputs agree with the register from the first edge.
  localparam csc_osc_ctrl_t osc_ctrl_reset = '{
    main_crystal_oscillator_run: 1'b0,
    ext_clock_valid: 1'b0,
    sub_crystal_oscillator_run: 1'b0,
    internal_osc_run: 1'b1,
    main_osc_gain_high: 1'b0
  };

  // True when the bus address selects the given register.
  function automatic logic reg_hit(input logic [19:0] addr, input logic [19:0] target);
    return addr == target;
  endfunction

  // A stop bit only matters for a pin pair that is set up as an oscillator or clock input.
  function automatic logic source_enabled(input logic mode_active, input logic stop_bit);
    return mode_active && !stop_bit;
  endfunction

  // Applies a bit write or a byte write to an old register value.
  function automatic logic [7:0] merge_write(input logic [7:0] old_value, input logic is_byte,
                                             input logic [2:0] bit_index, input logic [7:0] data);
    logic [7:0] result;
    result = old_value;
    if (is_byte) begin
      result = data;
    end else begin
      result[bit_index] = data[0];
    end
    return result;
  endfunction

  // Address decode and write qualification.
  wire hit_pin_mode = reg_hit(bus_addr, `CSC_ADDR_PIN_MODE);
  wire hit_stop_ctrl = reg_hit(bus_addr, `CSC_ADDR_STOP_CTRL);
  wire cfg_open = cfg_state == CSC_CFG_OPEN;
  // A bit write to the pin mode register neither loads nor locks it, since only byte writes count.
  wire pin_mode_load = bus_write && bus_byte && hit_pin_mode && cfg_open; // [RULE_01]
  wire stop_write = bus_write && hit_stop_ctrl; // [RULE_10]
  wire [7:0] pin_mode_masked = bus_wdata & `CSC_PIN_MODE_MASK;
  // Bit writes merge into the current value before the reserved bits are masked.
  wire [7:0] stop_merged = merge_write(clock_osc_stop_control, bus_byte, bus_bit, bus_wdata);
  wire [7:0] stop_masked = stop_merged & `CSC_STOP_CTRL_MASK;
  wire [1:0] main_pin_mode = {clock_pin_mode_config[`CSC_BIT_EXT_CLOCK_SELECT],
                              clock_pin_mode_config[`CSC_BIT_MAIN_OSC_PIN_SELECT]};
  wire main_is_crystal = main_pin_mode == `CSC_MODE_CRYSTAL; // [RULE_05]
  wire main_is_ext = main_pin_mode == `CSC_MODE_EXT_CLOCK; // [RULE_05]
  wire sub_is_crystal = clock_pin_mode_config[`CSC_BIT_SUB_OSC_PIN_SELECT]; // [RULE_06]
  // Stop bits of the stop control register.
  wire main_stop = clock_osc_stop_control[`CSC_BIT_HIGHSPEED_CLOCK_STOP];
  wire sub_stop = clock_osc_stop_control[`CSC_BIT_SUB_CLOCK_STOP];
  wire int_stop = clock_osc_stop_control[`CSC_BIT_INTERNAL_OSC_STOP];

  // Reserved bits are masked on the way in, so they always read back as zero.
  assign next_pin_mode = pin_mode_load ? pin_mode_masked : clock_pin_mode_config; // [RULE_01] [RULE_02]
  assign next_stop_ctrl = stop_write ? stop_masked : clock_osc_stop_control; // [RULE_10]
  // Main and sub stop bits act only on pin pairs in an oscillator or clock mode; the internal stop bit always acts.
  assign next_osc_ctrl.main_crystal_oscillator_run = source_enabled(main_is_crystal, main_stop); // [RULE_11]
  assign next_osc_ctrl.ext_clock_valid = source_enabled(main_is_ext, main_stop); // [RULE_11]
  assign next_osc_ctrl.sub_crystal_oscillator_run = source_enabled(sub_is_crystal, sub_stop); // [RULE_12]
  assign next_osc_ctrl.internal_osc_run = source_enabled(1'b1, int_stop); // [RULE_13]
  assign next_osc_ctrl.main_osc_gain_high = clock_pin_mode_config[`CSC_BIT_MAIN_OSC_GAIN_HIGH]; // [RULE_07]
  // Reads return register contents; the stop guards are software's duty and are not enforced.
  assign next_rdata = hit_pin_mode ? clock_pin_mode_config : // [RULE_03]
                      hit_stop_ctrl ? clock_osc_stop_control : 8'h00;
  // Status flags are plain registered copies; the select logic that drives them lives outside this block.
  assign next_cpu_on_subclock_flag = cpu_clock_select_sub; // [RULE_19]
  assign next_main_source_is_highspeed_flag = main_clock_select_highspeed; // [RULE_19]
  assign next_cpu_from_highspeed = main_clock_select_highspeed && !cpu_clock_select_sub;
  // The clear request follows the stop bit being written this cycle, so it rises together with the register.
  assign next_stabilization_clear = next_stop_ctrl[`CSC_BIT_HIGHSPEED_CLOCK_STOP]; // [RULE_21]

  // The configuration register holds its value once locked; only reset opens it again.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clock_pin_mode_config <= `CSC_PIN_MODE_RESET; // [RULE_04]
    end else begin
      clock_pin_mode_config <= next_pin_mode; // [RULE_01]
    end
  end

  // An illegal lock code falls to the locked side, because a stray reload could retune a running oscillator.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_state <= CSC_CFG_OPEN;
    end else begin
      unique case (cfg_state)
        CSC_CFG_OPEN: begin
          if (pin_mode_load) begin
            cfg_state <= CSC_CFG_LOCKED; // [RULE_02]
          end
        end
        CSC_CFG_LOCKED: begin
          cfg_state <= CSC_CFG_LOCKED; // [RULE_02]
        end
        default: begin
          cfg_state <= CSC_CFG_LOCKED;
        end
      endcase
    end
  end

  // Stop control accepts bit and byte writes at any time.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clock_osc_stop_control <= `CSC_STOP_CTRL_RESET; // [RULE_10]
    end else begin
      clock_osc_stop_control <= next_stop_ctrl; // [RULE_10]
    end
  end

  // Enables lag the registers by one cycle so that every output comes from a flip-flop.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      osc_ctrl <= osc_ctrl_reset; // [RULE_10]
    end else begin
      osc_ctrl <= next_osc_ctrl;
    end
  end

  // Read data lags the address by one cycle for the same reason.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus_rdata <= 8'h00;
    end else begin
      bus_rdata <= next_rdata; // [RULE_03]
    end
  end

  // Flags mirror the select inputs one cycle late.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cpu_on_subclock_flag <= 1'b0;
    end else begin
      cpu_on_subclock_flag <= next_cpu_on_subclock_flag; // [RULE_19]
    end
  end

  // The main source flag follows the same one-cycle lag.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      main_source_is_highspeed_flag <= 1'b0;
    end else begin
      main_source_is_highspeed_flag <= next_main_source_is_highspeed_flag; // [RULE_19]
    end
  end

  // Cleared by reset so the CPU starts from the internal oscillator whatever the select inputs show.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cpu_clock_from_highspeed <= 1'b0; // [RULE_20]
    end else begin
      cpu_clock_from_highspeed <= next_cpu_from_highspeed;
    end
  end

  // The main clock is stopped after reset, so the stabilization status starts out cleared.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stabilization_clear <= 1'b1; // [RULE_21]
    end else begin
      stabilization_clear <= next_stabilization_clear; // [RULE_21]
    end
  end
endmodule // csc_clock_source_ctrl

// ==== tb/csc_chk_sva.sv ====
// Port assertions for the clock source control block.
`timescale 1ns/10ps
module csc_chk
  import csc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [19:0] bus_addr,
  input wire logic bus_write,
  input wire logic bus_byte,
  input wire logic [7:0] bus_wdata,
  input wire logic cpu_clock_select_sub,
  input wire logic [7:0] bus_rdata,
  input wire csc_osc_ctrl_t osc_ctrl,
  input wire logic cpu_on_subclock_flag,
  input wire logic cpu_clock_from_highspeed,
  input wire logic stabilization_clear
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire wr_pin = bus_write && bus_byte && bus_addr == 20'hf_ffa0;
  wire wr_stop = bus_write && bus_byte && bus_addr == 20'hf_ffa1;
  logic locked;
  // Only one configuration write counts per reset, so track whether it has been spent.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) locked <= 1'b0;
    else if (wr_pin) locked <= 1'b1;
  end
  property p_first; !locked && wr_pin |-> ##2 osc_ctrl.main_osc_gain_high == $past(bus_wdata[0], 2); endproperty
  a_first: assert property (p_first) else $error("first config write lost");
  property p_lock; locked && wr_pin |-> ##2 $stable(osc_ctrl.main_osc_gain_high); endproperty
  a_lock: assert property (p_lock) else $error("late config write took effect");
  property p_stab; wr_stop |=> stabilization_clear == $past(bus_wdata[7]); endproperty
  a_stab: assert property (p_stab) else $error("stabilization clear wrong");
  property p_int; wr_stop ##1 !bus_write |-> ##1 osc_ctrl.internal_osc_run == !$past(bus_wdata[0], 2); endproperty
  a_int: assert property (p_int) else $error("internal osc enable wrong");
  property p_hs; stabilization_clear |=> !osc_ctrl.main_crystal_oscillator_run && !osc_ctrl.ext_clock_valid; endproperty
  a_hs: assert property (p_hs) else $error("main clock runs while stopped");
  property p_flag; !$past(reset) |-> cpu_on_subclock_flag == $past(cpu_clock_select_sub); endproperty
  a_flag: assert property (p_flag) else $error("subclock flag wrong");
  property p_cpu; $past(reset) |-> !cpu_clock_from_highspeed; endproperty
  a_cpu: assert property (p_cpu) else $error("cpu not on internal osc after reset");
  property p_rsv; (bus_rdata & 8'h2e) == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
endmodule // csc_chk
bind csc_clock_source_ctrl csc_chk chk_u (.*);

// ==== tb/tb_top.sv ====
// Self-checking bench for the clock source control block.
`timescale 1ns/10ps
module tb_top;
  import csc_pkg::*;
  localparam logic [19:0] pm_a = 20'hf_ffa0;
  localparam logic [19:0] sc_a = 20'hf_ffa1;
  logic clk = 0, reset = 1, bus_write = 0, bus_byte = 1, sub_in = 0, hs_in = 0;
  logic [19:0] bus_addr = 20'h0_0000;
  logic [2:0] bus_bit = 3'h0;
  logic [7:0] bus_wdata = 8'h00, bus_rdata;
  logic sub_flag, hs_flag, cpu_hs, stab_clr;
  csc_osc_ctrl_t osc;
  int err_count = 0, n_checks = 0;
  // Row: stop control byte, its read-back, oscillator enables with config 51h; the CPU stays on the internal osc.
  logic [20:0] rows [4] = '{{8'h00, 8'h00, 5'h17}, {8'hc0, 8'hc0, 5'h03}, {8'h80, 8'h80, 5'h07}, {8'hfe, 8'hc0, 5'h03}};
  csc_clock_source_ctrl dut_u (.clk, .reset, .bus_addr, .bus_write, .bus_byte, .bus_bit, .bus_wdata,
    .cpu_clock_select_sub(sub_in), .main_clock_select_highspeed(hs_in), .bus_rdata, .osc_ctrl(osc),
    .cpu_on_subclock_flag(sub_flag), .main_source_is_highspeed_flag(hs_flag),
    .cpu_clock_from_highspeed(cpu_hs), .stabilization_clear(stab_clr));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic b, input logic [2:0] n, input logic [7:0] d);
    @(posedge clk) #1;
    {bus_addr, bus_byte, bus_bit, bus_wdata, bus_write} = {a, b, n, d, 1'b1};
    @(posedge clk) #1;
    bus_write = 0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] e);
    @(posedge clk) #1;
    bus_addr = a;
    repeat (2) @(posedge clk);
    #1 chk(bus_rdata, e);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial forever #20 clk = ~clk;
  initial begin
    repeat (2) @(posedge clk);
    #1 reset = 0;
    chk({osc, stab_clr, cpu_hs, sub_flag}, 8'h14);
    rd(pm_a, 8'h00);
    rd(sc_a, 8'hc0);
    // A bit write must neither load the configuration nor use up its single write.
    wr(pm_a, 0, 3'h0, 8'h01);
    rd(pm_a, 8'h00);
    wr(pm_a, 1, 3'h0, 8'h51);
    wr(pm_a, 1, 3'h0, 8'hd0);
    rd(pm_a, 8'h51);
    for (int i = 0; i < 4; i++) begin
      wr(sc_a, 1, 3'h0, rows[i][20:13]);
      rd(sc_a, rows[i][12:5]);
      chk({3'h0, osc}, {3'h0, rows[i][4:0]});
      chk({7'h0, stab_clr}, {7'h0, rows[i][20]});
    end
    wr(sc_a, 0, 3'h7, 8'h00);
    rd(sc_a, 8'h40);
    chk({3'h0, osc}, 8'h13);
    chk({7'h0, stab_clr}, 8'h00);
    wr(sc_a, 1, 3'h0, 8'h00);
    // With the CPU on the subclock both the main clock and the internal oscillator may be stopped.
    sub_in = 1;
    wr(sc_a, 1, 3'h0, 8'h81);
    rd(sc_a, 8'h81);
    chk({3'h0, osc}, 8'h05);
    {sub_in, hs_in} = 2'b11;
    @(posedge clk) #1 chk({5'h0, sub_flag, hs_flag, cpu_hs}, 8'h06);
    sub_in = 0;
    @(posedge clk) #1 chk({5'h0, sub_flag, hs_flag, cpu_hs}, 8'h03);
    rd(20'hf_ffa2, 8'h00);
    reset = 1;
    @(posedge clk) #1 reset = 0;
    rd(pm_a, 8'h00);
    wr(pm_a, 1, 3'h0, 8'hc3);
    wr(sc_a, 1, 3'h0, 8'h00);
    rd(pm_a, 8'hc1);
    chk({3'h0, osc}, 8'h0b);
    reset = 1;
    @(posedge clk) #1 reset = 0;
    wr(pm_a, 1, 3'h0, 8'h00);
    wr(pm_a, 1, 3'h0, 8'hc3);
    rd(pm_a, 8'h00);
    close_out();
  end
endmodule // tb_top
